//--- logic/can_txp_pkg.sv
// Constants, register map and carrier types of the Tx pending block.
// Assumes a single clock domain and a 32-bit AHB-Lite register bus.
package can_txp_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_BUF = 32;           // Transmit buffers
  localparam int IDX_W   = 5;            // Buffer index width
  localparam int ID_W    = 29;           // Message identifier width
  localparam int IRQ_W   = 30;           // Interrupt flag count
  localparam int ADDR_W  = 12;           // Decoded address bits

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [11:0] OFS_CTRL      = 12'h018;
  localparam logic [11:0] OFS_IRQ_FLAGS = 12'h050;
  localparam logic [11:0] OFS_IRQ_EN    = 12'h054;
  localparam logic [11:0] OFS_LINE_SEL  = 12'h058;
  localparam logic [11:0] OFS_LINE_EN   = 12'h05C;
  localparam logic [11:0] OFS_TX_CFG    = 12'h0C0;
  localparam logic [11:0] OFS_TX_PEND   = 12'h0C4;
  localparam logic [11:0] OFS_TX_ADD    = 12'h0C8;
  localparam logic [11:0] OFS_TX_CANCEL = 12'h0CC;
  localparam logic [11:0] OFS_TX_OCC    = 12'h0D0;
  localparam logic [11:0] OFS_TX_CFIN   = 12'h0D4;
  localparam logic [11:0] OFS_ID_BASE   = 12'h100;  // 32 words

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_NO_RETX = 0;       // No automatic retransmit
  localparam int IRQ_TC       = 9;       // Transmission completed
  localparam int IRQ_TCF      = 10;      // Cancellation finished
  localparam int IRQ_PEA      = 27;      // Arbitration-phase error
  localparam int IRQ_PED      = 28;      // Data-phase error
  localparam int IRQ_ARA      = 29;      // Reserved address access

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [1:0]  RST_LINE_EN = 2'h0;

  // ****************************************************************
  // Carriers and states
  // ****************************************************************
  typedef struct packed {
    logic             start;             // Frame started, pulse
    logic             done;              // Frame ended, pulse
    logic             success;           // Qualifies done
    logic [IDX_W-1:0] idx;               // Buffer started
    logic [IRQ_W-1:0] events;            // Engine flag pulses
  } engine_in_s;

  typedef struct packed {
    logic [NUM_BUF-1:0] pending;         // Pending request bits
    logic               scanStart;       // Scan kicked off
    logic               scanDone;        // Result valid pulse
    logic               bestValid;       // A candidate was found
    logic [IDX_W-1:0]   bestIdx;         // Lowest identifier buffer
  } engine_out_s;

  typedef enum {SCAN_IDLE, SCAN_RUN, SCAN_LAST} scan_state_e;

endpackage

//--- logic/tx_id_mem.sv
// Small identifier memory, one write port and one registered read.
// Assumes writer and reader share the clock.
`timescale 1ns/10ps
module tx_id_mem #(
  parameter int DEPTH = 32,
  parameter int AW    = 5,
  parameter int W     = 29
) (
  input  wire logic          ref_clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata_r
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [W-1:0] mem [DEPTH];             // Identifier words

  // Write port; contents are undefined until software fills them
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read, one cycle latency
  always_ff @(posedge ref_clk) begin
    rdata_r <= mem[raddr];
  end

endmodule // tx_id_mem

//--- logic/tx_prio_scan.sv
// Walks all buffers and finds the pending one with lowest identifier.
// Assumes a memory with one cycle read latency on the same clock.
`timescale 1ns/10ps
module tx_prio_scan
  import can_txp_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               start,
  input  wire logic [NUM_BUF-1:0] pending,
  output logic      [IDX_W-1:0]   raddr,
  input  wire logic [ID_W-1:0]    rdata,
  output logic                    done_r,
  output logic                    found_r,
  output logic      [IDX_W-1:0]   bestIdx_r
);

  // ****************************************************************
  // State
  // ****************************************************************
  scan_state_e      state_r;             // Scan phase
  logic [IDX_W-1:0] cnt_r;               // Address being read
  logic [IDX_W-1:0] cmpIdx_r;            // Index of data in rdata
  logic             cmpValid_r;          // rdata is to be compared
  logic [ID_W-1:0]  bestId_r;            // Lowest identifier so far
  logic             better;              // Candidate beats best

  assign raddr  = cnt_r;
  // Pending sampled at compare time, so a bit cleared before its compare drops
  assign better = cmpValid_r && pending[cmpIdx_r] &&
                  (!found_r || rdata < bestId_r);

  // Sequencing; a new start restarts from buffer zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r    <= SCAN_IDLE;
      cnt_r      <= '0;
      cmpValid_r <= 1'b0;
      cmpIdx_r   <= '0;
      done_r     <= 1'b0;
    end else begin
      done_r     <= 1'b0;
      cmpValid_r <= (state_r == SCAN_RUN) && !start;
      cmpIdx_r   <= cnt_r;
      if (start) begin
        state_r <= SCAN_RUN;
        cnt_r   <= '0;
      end else begin
        case (state_r)
          SCAN_RUN: begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == IDX_W'(NUM_BUF - 1)) begin
              state_r <= SCAN_LAST;
            end
          end
          SCAN_LAST: begin
            // Last compare happens this cycle
            state_r <= SCAN_IDLE;
            done_r  <= 1'b1;
          end
          default: begin
            state_r <= SCAN_IDLE;
          end
        endcase
      end
    end
  end

  // Running minimum; cleared at each start
  always_ff @(posedge ref_clk) begin
    if (!rst_n || start) begin
      found_r   <= 1'b0;
      bestId_r  <= '0;
      bestIdx_r <= '0;
    end else if (better) begin
      found_r   <= 1'b1;
      bestId_r  <= rdata;
      bestIdx_r <= cmpIdx_r;
    end
  end

endmodule // tx_prio_scan

//--- logic/can_tx_pending_and_irq_lines.sv
// Tx request pending tracking and interrupt line routing.
// Assumes an AHB-Lite master on ref_clk and a protocol engine on the
// same clock that reports frame start and frame end.
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
module can_tx_pending_and_irq_lines
  import can_txp_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  input  wire logic                     hsel,
  input  wire logic [ADDR_W-1:0]        haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic      [31:0]              hrdata,
  input  wire can_txp_pkg::engine_in_s  engIn,
  output can_txp_pkg::engine_out_s      engOut,
  output logic                          irqLine0,
  output logic                          irqLine1
);
  import can_txp_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Buffer index to one-hot mask
  function automatic logic [NUM_BUF-1:0] oneHot(
    input logic [IDX_W-1:0] idx
  );
    oneHot      = '0;
    oneHot[idx] = 1'b1;
  endfunction

  // Offset falls in the identifier window
  function automatic logic inIdWin(input logic [ADDR_W-1:0] a);
    inIdWin = (a >= OFS_ID_BASE) &&
              (a < OFS_ID_BASE + ADDR_W'(NUM_BUF * 4));
  endfunction

  // Offset is a mapped register or window word
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CTRL, OFS_IRQ_FLAGS, OFS_IRQ_EN, OFS_LINE_SEL,
      OFS_LINE_EN, OFS_TX_CFG, OFS_TX_PEND, OFS_TX_ADD,
      OFS_TX_CANCEL, OFS_TX_OCC, OFS_TX_CFIN: isMapped = 1'b1;
      default: isMapped = inIdWin(a);
    endcase
  endfunction

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic              addrPhase;          // Transfer accepted now
  logic              wrPend_r;           // Write data phase
  logic [ADDR_W-1:0] wrAddr_r;           // Latched write address
  logic              badAccess;          // Unmapped access pulse
  logic [31:0]       rdMux;              // Read value at haddr

  // Slave never stalls and never errors
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  // Size is not checked: only whole words are expected
  assign addrPhase = hsel && hready && htrans[1];
  assign badAccess = addrPhase && !isMapped(haddr);

  // Address phase capture for writes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= '0;
    end else begin
      wrPend_r <= addrPhase && hwrite;
      wrAddr_r <= {haddr[ADDR_W-1:2], 2'b00};
    end
  end

  // Write strobe for one register in the data phase
  function automatic logic wrHit(input logic [ADDR_W-1:0] ofs);
    wrHit = wrPend_r && (wrAddr_r == ofs);
  endfunction

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic               noRetx_r;          // No automatic retransmit
  logic [IRQ_W-1:0]   irqEn_r;           // Flag enables
  logic [IRQ_W-1:0]   lineSel_r;         // Line select per flag
  logic [1:0]         lineEn_r;          // Per line enables
  logic [NUM_BUF-1:0] txCfg_r;           // Buffers in use

  // Software written settings, all zero after reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      noRetx_r  <= RST_WORD[0];
      irqEn_r   <= RST_WORD[IRQ_W-1:0];
      lineSel_r <= RST_WORD[IRQ_W-1:0];
      lineEn_r  <= RST_LINE_EN;
      txCfg_r   <= RST_WORD;
    end else begin
      if (wrHit(OFS_CTRL)) begin
        noRetx_r <= hwdata[CTRL_NO_RETX];
      end
      if (wrHit(OFS_IRQ_EN)) begin
        irqEn_r <= hwdata[IRQ_W-1:0];
      end
      if (wrHit(OFS_LINE_SEL)) begin
        // Bits 29..27 hold the special selects
        lineSel_r <= hwdata[IRQ_W-1:0];
      end
      if (wrHit(OFS_LINE_EN)) begin
        lineEn_r <= hwdata[1:0];
      end
      if (wrHit(OFS_TX_CFG)) begin
        txCfg_r <= hwdata;
      end
    end
  end

  // ****************************************************************
  // Active frame tracking
  // ****************************************************************
  logic             activeValid_r;       // Engine is sending a frame
  logic [IDX_W-1:0] activeIdx_r;         // Buffer being sent

  // Start marks the buffer, done releases it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      activeValid_r <= 1'b0;
      activeIdx_r   <= '0;
    end else if (engIn.start) begin
      activeValid_r <= 1'b1;
      activeIdx_r   <= engIn.idx;
    end else if (engIn.done) begin
      activeValid_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Pending, cancel and result bits
  // ****************************************************************
  logic [NUM_BUF-1:0] pending_r;         // Request outstanding
  logic [NUM_BUF-1:0] cancel_r;          // Cancel requested
  logic [NUM_BUF-1:0] occurred_r;        // Sent successfully
  logic [NUM_BUF-1:0] cancelFin_r;       // Cancel finished
  logic [NUM_BUF-1:0] clearedLast_r;     // Pending cleared last cycle
  logic [NUM_BUF-1:0] addMask;           // Accepted add requests
  logic [NUM_BUF-1:0] cancelSet;         // Written cancel bits
  logic [NUM_BUF-1:0] busyMask;          // Frame on the wire
  logic [NUM_BUF-1:0] doneMask;          // Frame ending now
  logic [NUM_BUF-1:0] okMask;            // Ended with success
  logic [NUM_BUF-1:0] failDrop;          // Failed and given up
  logic [NUM_BUF-1:0] cancelIdle;        // Cancelled before start
  logic [NUM_BUF-1:0] clearMask;         // Pending bits to clear
  logic [NUM_BUF-1:0] finSet;            // Cancel finished events

  // Add only configured, idle buffers
  assign addMask   = wrHit(OFS_TX_ADD) ?
                     (hwdata & txCfg_r & ~pending_r) : '0;
  assign cancelSet = wrHit(OFS_TX_CANCEL) ? hwdata : '0;
  // A buffer starting this cycle counts as busy already
  assign busyMask  = (activeValid_r ? oneHot(activeIdx_r) : '0) |
                     (engIn.start ? oneHot(engIn.idx) : '0);
  assign doneMask  = (engIn.done && activeValid_r) ?
                     oneHot(activeIdx_r) : '0;
  assign okMask    = engIn.success ? doneMask : '0;
  // Failure drops the request if cancelled or retransmit is off
  assign failDrop  = (engIn.success ? '0 : doneMask) &
                     (cancel_r | {NUM_BUF{noRetx_r}});
  // Busy buffers keep pending until frame end
  assign cancelIdle = cancel_r & pending_r & ~busyMask;
  assign clearMask = okMask | failDrop | cancelIdle;
  assign finSet    = (okMask & cancel_r) | failDrop |
                     cancelIdle;

  // Pending word, read only to software
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pending_r <= RST_WORD;
    end else begin
      pending_r <= (pending_r & ~clearMask) | addMask;
    end
  end

  // Cancel bits drop one cycle after their pending bit; a new
  // software write in that cycle wins over the drop
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cancel_r      <= RST_WORD;
      clearedLast_r <= RST_WORD;
    end else begin
      clearedLast_r <= clearMask;
      cancel_r      <= (cancel_r & ~clearedLast_r) |
                       cancelSet;
    end
  end

  // Result bits, cleared by a new add request for the buffer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      occurred_r  <= RST_WORD;
      cancelFin_r <= RST_WORD;
    end else begin
      occurred_r  <= (occurred_r & ~addMask) | okMask;
      cancelFin_r <= (cancelFin_r & ~addMask) | finSet;
    end
  end

  // ****************************************************************
  // Priority scan
  // ****************************************************************
  logic             scanStart_r;         // One cycle kick
  logic [IDX_W-1:0] idRdAddr;            // Scanner read address
  logic [ID_W-1:0]  idRdData;            // Identifier read back
  logic             scanDone;            // Scan result pulse
  logic             scanFound;           // Candidate present
  logic [IDX_W-1:0] scanIdx;             // Winning buffer

  // Any newly set pending bit restarts the scan
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      scanStart_r <= 1'b0;
    end else begin
      scanStart_r <= |addMask;
    end
  end

  // Identifier store written through the bus window
  tx_id_mem #(
    .DEPTH (NUM_BUF),
    .AW    (IDX_W),
    .W     (ID_W)
  ) u_id_mem (
    .ref_clk (ref_clk),
    .we      (wrPend_r && inIdWin(wrAddr_r)),
    .waddr   (wrAddr_r[IDX_W+1:2]),
    .wdata   (hwdata[ID_W-1:0]),
    .raddr   (idRdAddr),
    .rdata_r (idRdData)
  );

  // Lowest identifier among pending buffers wins
  tx_prio_scan u_scan (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .start     (scanStart_r),
    .pending   (pending_r),
    .raddr     (idRdAddr),
    .rdata     (idRdData),
    .done_r    (scanDone),
    .found_r   (scanFound),
    .bestIdx_r (scanIdx)
  );

  assign engOut.pending   = pending_r;
  assign engOut.scanStart = scanStart_r;
  assign engOut.scanDone  = scanDone;
  assign engOut.bestValid = scanFound;
  assign engOut.bestIdx   = scanIdx;

  // ****************************************************************
  // Interrupt flags and lines
  // ****************************************************************
  logic [IRQ_W-1:0] irqFlags_r;          // Sticky event flags
  logic [IRQ_W-1:0] irqSet;              // Events this cycle
  logic [IRQ_W-1:0] irqClr;              // Write-one-to-clear
  logic [IRQ_W-1:0] irqLive;             // Flags that are enabled

  always_comb begin
    irqSet          = engIn.events;
    irqSet[IRQ_TC]  = engIn.events[IRQ_TC] | (|okMask);
    irqSet[IRQ_TCF] = engIn.events[IRQ_TCF] | (|finSet);
    irqSet[IRQ_ARA] = engIn.events[IRQ_ARA] | badAccess;
  end
  assign irqClr = wrHit(OFS_IRQ_FLAGS) ? hwdata[IRQ_W-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irqFlags_r <= RST_WORD[IRQ_W-1:0];
    end else begin
      irqFlags_r <= (irqFlags_r & ~irqClr) | irqSet;
    end
  end

  // Select zero routes to line zero
  assign irqLive  = irqFlags_r & irqEn_r;
  assign irqLine0 = lineEn_r[0] && |(irqLive & ~lineSel_r);
  assign irqLine1 = lineEn_r[1] && |(irqLive & lineSel_r);

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Write-only and unmapped words read zero
  always_comb begin
    rdMux = '0;
    case ({haddr[ADDR_W-1:2], 2'b00})
      OFS_CTRL:      rdMux[CTRL_NO_RETX] = noRetx_r;
      OFS_IRQ_FLAGS: rdMux[IRQ_W-1:0]    = irqFlags_r;
      OFS_IRQ_EN:    rdMux[IRQ_W-1:0]    = irqEn_r;
      OFS_LINE_SEL:  rdMux[IRQ_W-1:0]    = lineSel_r;
      OFS_LINE_EN:   rdMux[1:0]          = lineEn_r;
      OFS_TX_CFG:    rdMux               = txCfg_r;
      OFS_TX_PEND:   rdMux               = pending_r;
      OFS_TX_CANCEL: rdMux               = cancel_r;
      OFS_TX_OCC:    rdMux               = occurred_r;
      OFS_TX_CFIN:   rdMux               = cancelFin_r;
      default:       rdMux               = '0;
    endcase
  end

  // Read data registered at the address phase edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hrdata <= RST_WORD;
    end else if (addrPhase && !hwrite) begin
      hrdata <= rdMux;
    end
  end

endmodule // can_tx_pending_and_irq_lines

//--- tb/can_txp_asserts.sv
// Port checker for the Tx pending block, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module can_txp_asserts (
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  input wire logic                    hsel,
  input wire logic [11:0]             haddr,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic [31:0]             hwdata,
  input wire logic                    hready,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  input wire logic [31:0]             hrdata,
  input wire can_txp_pkg::engine_in_s  engIn,
  input wire can_txp_pkg::engine_out_s engOut,
  input wire logic                    irqLine0,
  input wire logic                    irqLine1
);
  import can_txp_pkg::*;
  logic        dpWr_r, dpRd_r, lenW_r, busy_r; // Data phase, frame state
  logic [11:0] dpA_r;                          // Data phase address
  logic [31:0] prev_r;                         // Pending one cycle back
  logic [4:0]  act_r;                          // Buffer on the wire
  wire logic [31:0] newB = engOut.pending & ~prev_r;
  wire logic wAdd = dpWr_r && dpA_r == OFS_TX_ADD;
  wire logic wCnl = dpWr_r && dpA_r == OFS_TX_CANCEL;
  // Track bus phases and the frame in flight
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {dpWr_r, dpRd_r, lenW_r, busy_r, dpA_r, prev_r, act_r} <= '0;
    end else begin
      dpWr_r <= hsel && hready && htrans[1] && hwrite;
      dpRd_r <= hsel && hready && htrans[1] && !hwrite;
      dpA_r  <= haddr;
      lenW_r <= lenW_r || (dpWr_r && dpA_r == OFS_LINE_EN);
      prev_r <= engOut.pending;
      busy_r <= engIn.start || (busy_r && !engIn.done);
      if (engIn.start) begin
        act_r <= engIn.idx;
      end
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_ok; hreadyout && !hresp; endproperty
  a_ok: assert property (p_ok) else $error("bus not ready");
  property p_add;
    newB != 0 |-> $past(wAdd) && (newB & ~$past(hwdata)) == 0;
  endproperty
  a_add: assert property (p_add) else $error("stray pending");
  property p_scan; newB != 0 |-> ##[0:1] engOut.scanStart; endproperty
  a_scan: assert property (p_scan) else $error("no scan");
  property p_sdone;
    engOut.scanStart |-> ##[1:40] (engOut.scanDone || engOut.scanStart);
  endproperty
  a_sdone: assert property (p_sdone) else $error("scan hung");
  property p_fall;
    (prev_r & ~engOut.pending) != 0 |-> $past(engIn.done)
      || $past(engIn.done, 2) || $past(wCnl, 2) || $past(wCnl, 3);
  endproperty
  a_fall: assert property (p_fall) else $error("bad clear");
  property p_act;
    busy_r && !engIn.done && engOut.pending[act_r]
      |=> engOut.pending[act_r];
  endproperty
  a_act: assert property (p_act) else $error("early clear");
  property p_rd; dpRd_r && dpA_r == OFS_TX_PEND |-> hrdata == prev_r;
  endproperty
  a_rd: assert property (p_rd) else $error("pending read");
  property p_rst;
    $rose(rst_n) |-> !irqLine0 && !irqLine1 && engOut == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_quiet; !lenW_r |-> !irqLine0 && !irqLine1; endproperty
  a_quiet: assert property (p_quiet) else $error("line on");
  c_scan: cover property (engOut.scanDone && engOut.bestValid);
  c_cnl: cover property (busy_r && wCnl);
  c_line: cover property (irqLine1);
endmodule // can_txp_asserts
bind can_tx_pending_and_irq_lines can_txp_asserts u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .engIn(engIn),
  .engOut(engOut), .irqLine0(irqLine0), .irqLine1(irqLine1));

//--- tb/can_engine_model.sv
// Protocol engine stand-in: frame start, frame end, flag pulses.
// Assumes the block samples engIn at every rising ref_clk edge.
`timescale 1ns/10ps
module can_engine_model (
  input wire logic              ref_clk,
  output can_txp_pkg::engine_in_s engIn
);
  import can_txp_pkg::*;
  initial engIn = '0; // Quiet from time zero
  // Frame begins for buffer i
  task automatic begin_f(input logic [IDX_W-1:0] i);
    @(posedge ref_clk);
    engIn.start <= 1'b1;
    engIn.idx <= i;
    @(posedge ref_clk);
    engIn.start <= 1'b0;
  endtask
  // Frame ends; ok low stands for lost arbitration or frame error
  task automatic end_f(input logic ok);
    @(posedge ref_clk);
    engIn.done <= 1'b1;
    engIn.success <= ok;
    @(posedge ref_clk);
    engIn.done <= 1'b0;
    engIn.success <= ~ok;    // Unqualified now, so not left steady
    engIn.idx <= ~engIn.idx; // Same reason for the released index
  endtask
  // One-cycle flag pulse from the engine
  task automatic evt(input int n);
    @(posedge ref_clk);
    engIn.events[n] <= 1'b1;
    @(posedge ref_clk);
    engIn.events <= '0;
  endtask
endmodule // can_engine_model

//--- tb/can_tx_pending_and_irq_lines_test.sv
// Self-checking bench: register tasks, engine stand-in, scenarios.
// Assumes the design package and the checker are compiled first.
`timescale 1ns/10ps
module can_tx_pending_and_irq_lines_test;
  import can_txp_pkg::*;
  logic ref_clk = 0, rst_n = 0, hsel = 0, hwrite = 0;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h0; // Word size in address phases only
  logic [31:0] hwdata = '0, hrdata, rdV;
  logic hreadyout, hresp, irqLine0, irqLine1;
  engine_in_s engIn;
  engine_out_s engOut;
  int bad_count = 0, checks = 0, n;
  logic [28:0] ids [4] = '{29'h12C, 29'h064, 29'h0C8, 29'h032};
  always #5 ref_clk = ~ref_clk;
  can_engine_model eng (.ref_clk(ref_clk), .engIn(engIn));
  can_tx_pending_and_irq_lines dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .engIn(engIn),
    .engOut(engOut), .irqLine0(irqLine0), .irqLine1(irqLine1));
  task automatic chk(input string w, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", w, e, s);
    end
  endtask
  // One AHB single transfer; read data taken at the data phase end
  task automatic xfer(input logic [11:0] a, input logic w, [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hsize <= 3'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rdV = hrdata;
  endtask
  task automatic rc(input string w, input logic [11:0] a, [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(w, rdV, e);
  endtask
  task automatic lc(input logic [1:0] e);
    @(negedge ref_clk);
    chk("lines", {30'h0, irqLine1, irqLine0}, {30'h0, e});
  endtask
  task automatic scanWait; // Bounded wait for the scan result pulse
    n = 0;
    do begin @(negedge ref_clk); n++; end
    while (engOut.scanDone !== 1'b1 && n < 80);
    chk("scan done", {31'h0, engOut.scanDone}, 32'h1);
    chk("found", {31'h0, engOut.bestValid}, 32'h1);
  endtask
  task automatic results;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rc("select", OFS_LINE_SEL, 32'h0);
    rc("pending", OFS_TX_PEND, 32'h0);
    xfer(OFS_LINE_SEL, 1'b1, 32'h38000000);
    rc("select", OFS_LINE_SEL, 32'h38000000);
    xfer(OFS_IRQ_EN, 1'b1, 32'h3FFFFFFF);
    xfer(OFS_LINE_EN, 1'b1, 32'h3);
    for (int b = 27; b < 29; b++) begin
      eng.evt(b);
      lc(2'h2);
      xfer(OFS_IRQ_FLAGS, 1'b1, 32'h1 << b);
      lc(2'h0);
    end
    rc("unmapped", 12'h7F0, 32'h0);
    lc(2'h2);
    xfer(OFS_LINE_SEL, 1'b1, 32'h0);
    lc(2'h1);
    xfer(OFS_IRQ_EN, 1'b1, 32'h0);
    lc(2'h0);
    xfer(OFS_TX_CFG, 1'b1, 32'hF);
    for (int i = 0; i < 4; i++)
      xfer(OFS_ID_BASE + 12'(4 * i), 1'b1, {3'h0, ids[i]});
    xfer(OFS_TX_ADD, 1'b1, 32'h30);
    xfer(OFS_TX_PEND, 1'b1, 32'hF);
    rc("pending", OFS_TX_PEND, 32'h0);
    xfer(OFS_TX_ADD, 1'b1, 32'h7);
    xfer(OFS_TX_ADD, 1'b1, 32'h1);
    rc("pending", OFS_TX_PEND, 32'h7);
    scanWait;
    chk("best", {27'h0, engOut.bestIdx}, 32'h1);
    eng.begin_f(5'h1);
    eng.end_f(1'b1);
    rc("pending", OFS_TX_PEND, 32'h5);
    rc("occurred", OFS_TX_OCC, 32'h2);
    xfer(OFS_TX_CANCEL, 1'b1, 32'h4);
    rc("pending", OFS_TX_PEND, 32'h1);
    rc("cancel", OFS_TX_CANCEL, 32'h0);
    rc("finished", OFS_TX_CFIN, 32'h4);
    eng.begin_f(5'h0);
    xfer(OFS_TX_CANCEL, 1'b1, 32'h1);
    rc("pending", OFS_TX_PEND, 32'h1);
    eng.end_f(1'b0);
    rc("pending", OFS_TX_PEND, 32'h0);
    rc("finished", OFS_TX_CFIN, 32'h5);
    xfer(OFS_CTRL, 1'b1, 32'h1);
    xfer(OFS_TX_ADD, 1'b1, 32'h8);
    scanWait;
    chk("best", {27'h0, engOut.bestIdx}, 32'h3);
    eng.begin_f(5'h3);
    eng.end_f(1'b0);
    rc("pending", OFS_TX_PEND, 32'h0);
    rc("finished", OFS_TX_CFIN, 32'hD);
    results;
  end
  initial begin // Watchdog well past the expected run length
    repeat (3000) @(posedge ref_clk);
    bad_count++;
    results;
  end
endmodule // can_tx_pending_and_irq_lines_test
